// ===== dv/prlct_phy_model.sv
// Purpose: Behavioural cable test engine of the two PHYs
// Assumes: One-cycle start pulse per port, i_lat of at least one
// Notes:   Result lines are only valid in the done cycle, inverted otherwise
`timescale 1ns/1ps
module prlct_phy_model (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Scenario from the bench
  input  wire logic [7:0]  i_lat,
  input  wire logic [1:0]  i_short,
  input  wire logic [3:0]  i_result,
  input  wire logic [17:0] i_count,
  // Engine handshake
  input  wire logic [1:0]  i_start,
  output logic      [1:0]  o_done,
  output logic      [1:0]  o_short,
  output logic      [3:0]  o_result,
  output logic      [17:0] o_count
);
  logic [7:0] cnt_q [2];
  logic [1:0] done_q;

  ////////////////////////////////////////
  // test end pulse
  always_ff @(posedge i_sys_clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      done_q[p] <= 1'b0;
      if (i_sys_rst)
        cnt_q[p] <= 8'h00;
      else if (i_start[p])
        cnt_q[p] <= i_lat;
      else if (cnt_q[p] != 8'h00)
      begin
        cnt_q[p]  <= cnt_q[p] - 8'h01;
        done_q[p] <= (cnt_q[p] == 8'h01);
      end
    end
  end

  // results only at done; a stale value would hide a late load
  assign o_done   = done_q;
  assign o_short  = i_short ^ ~done_q;
  assign o_result = i_result ^ ~{{2{done_q[1]}}, {2{done_q[0]}}};
  assign o_count  = i_count ^ ~{{9{done_q[1]}}, {9{done_q[0]}}};
endmodule : prlct_phy_model

// ===== dv/prlct_tb_top.sv
// Purpose: Self-checking bench for the rate-limit and cable-test registers
// Assumes: Host strobes last one cycle; the PHY model answers tests
// Notes:   Shaper recovery is judged in credit ticks, plus or minus one
`timescale 1ns/1ps
module prlct_tb_top;
  logic        clk, rst, wr, rd, mwr, mrd, gap, pre;
  logic [7:0]  addr, wdata, rdata, mrdata, lat, q, ad;
  logic [1:0]  start, done, dshort, loop, frc, l100, fv, allow, sh_e, fl_e, lb_e;
  logic [3:0]  dres, re_e;
  logic [17:0] dcount, ct_e;
  logic [21:0] flen;
  logic [7:0]  ra [8] = '{8'h1A, 8'h1B, 8'h29, 8'h2A, 8'h2B, 8'h39, 8'h00, 8'hFF};
  int          failures, n_checks, cyc, p, j;
  int unsigned r;

  prlct_regs dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_miim_port(addr[5]), .i_miim_wr(mwr),
    .i_miim_rd(mrd), .i_miim_wdata(wdata), .o_miim_rdata(mrdata), .o_diag_start(start),
    .i_diag_done(done), .i_diag_short(dshort), .i_diag_result(dres), .i_diag_count(dcount),
    .o_remote_loopback(loop), .o_force_link(frc), .i_gap_bytes_in_accounting(gap),
    .i_count_preamble(pre), .i_link_100(l100), .i_frame_valid(fv), .i_frame_len(flen),
    .o_priority_three_queue_allow(allow)
  );

  prlct_phy_model phy (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_lat(lat), .i_short(sh_e), .i_result(re_e),
    .i_count(ct_e), .i_start(start), .o_done(done), .o_short(dshort), .o_result(dres),
    .o_count(dcount)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////
  task automatic results();
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Host access on the register port (m=0) or the management mirror (m=1)
  task automatic acc(input bit m, input bit w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] o);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    {mwr, mrd, wr, rd} = {m & w, m & !w, !m & w, !m & !w};
    @(posedge clk) #1;
    {mwr, mrd, wr, rd} = 4'h0;
    o = m ? mrdata : rdata;
  endtask : acc

  function automatic logic [7:0] spec(input int s, input logic en);
    return {sh_e[s], re_e[s*2 +: 2], en, fl_e[s], 1'b0, lb_e[s], ct_e[s*9+8]};
  endfunction : spec

  // Rate in kbit/s, zero when the code means no limiting
  function automatic int kbps(input bit h, input logic [6:0] c);
    if (c == 7'h00)
      return 0;
    if (!h)
      return (c < 7'h0A) ? c * 1000 : 0;
    if (c < 7'h64)
      return c * 1000;
    return (c <= 7'h73) ? (c - 7'h64) * 64 : 0;
  endfunction : kbps

  // First pass drains credit so the measured pass starts just above zero
  task automatic meas(input int s, input bit h, input logic [6:0] c, input int len,
                      input bit g, input bit pr);
    int e, k, t, n;
    e = kbps(h, c);
    acc(0, 1, s ? 8'h39 : 8'h29, {1'b0, c}, q);
    l100[s] = h;
    gap = g;
    pre = pr;
    k = e ? ((len + 12 * g + 8 * pr) * 8000 + e - 1) / e : 0;
    for (n = 0; n < 2; n++)
    begin
      j = 0;
      do
      begin
        @(posedge clk) #1;
        flen[s*11 +: 11] = len[10:0];
        fv[s] = 1'b1;
        @(posedge clk) #1;
        fv[s] = 1'b0;
        @(posedge clk) #1;
        j++;
      end while (n == 0 && e != 0 && allow[s] === 1'b1 && j < 4000);
      t = 0;
      while (allow[s] !== 1'b1 && t < 90000)
      begin
        @(posedge clk) #1;
        t++;
      end
      t = (t + 99) / 100;
    end
    check((t + 1 >= k && t <= k + 1) ? k : t, k);
  endtask : meas

  ////////////////////////////////////////
  initial
  begin
    {clk, wr, rd, mwr, mrd, gap, pre, addr, wdata, l100, fv, flen} = '0;
    {sh_e, fl_e, lb_e, re_e, ct_e} = '0;
    lat = 8'h03;
    rst = 1'b1;
    r = $urandom(32'h7AF98895);
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    check({start, loop, frc, allow}, 8'h03);
    foreach (ra[k])
    begin
      acc(0, 0, ra[k], 8'h00, q);
      check(q, 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      ad = r[0] ? 8'h39 : 8'h29;
      acc(0, 1, ad, {1'b0, r[7:1]}, q);
      acc(0, 0, ad, 8'h00, q);
      check(q, {1'b0, r[7:1]});
    end
    for (int i = 0; i < 8; i++)
    begin
      p = i % 2;
      ad = p ? 8'h2A : 8'h1A;
      r = $urandom;
      lat = 8'h03 + 8'(r[15:10] % 30);
      sh_e[p] = r[0];
      re_e[p*2 +: 2] = 2'(i / 2);
      ct_e[p*9 +: 9] = r[9:1];
      acc(r[16], 1, ad, spec(p, 1) & 8'h1A, q);
      acc(!r[16], 0, ad, 8'h00, q);
      check(q[4], 1'b1);
      j = 0;
      while (q[4] !== 1'b0 && j < 40)
      begin
        acc(0, 0, ad, 8'h00, q);
        j++;
      end
      check(q, spec(p, 0));
      acc(0, 0, 8'h2B, 8'h00, q);
      check(q, ct_e[16:9]);
    end
    for (int i = 0; i < 8; i++)
    begin
      p = i % 2;
      ad = p ? 8'h2A : 8'h1A;
      r = $urandom;
      fl_e[p] = r[0];
      lb_e[p] = r[1];
      acc(r[2], 1, ad, spec(p, 0) ^ 8'hE5, q);
      acc(!r[2], 0, ad, 8'h00, q);
      check(q, spec(p, 0));
      check({loop[p], frc[p]}, {lb_e[p], fl_e[p]});
    end
    r = 1 + $urandom % 99;
    meas(0, 1, r[6:0], r, 0, 0);
    meas(1, 1, 7'h63, 99, 0, 0);
    r = 1 + $urandom % 9;
    meas(1, 0, r[6:0], r, 0, 0);
    r = 7'h6A + $urandom % 10;
    meas(0, 1, r[6:0], 1, 0, 0);
    meas(1, 1, 7'h73, 1, 0, 0);
    meas(1, 1, 7'h65, 1, 0, 0);
    for (int i = 0; i < 4; i++)
      meas(0, 0, 7'h09, 9, i[1], i[0]);
    meas(0, 1, 7'h00, 99, 0, 0);
    meas(1, 1, 7'h64, 99, 0, 0);
    meas(0, 0, 7'h00, 9, 0, 0);
    meas(1, 0, 7'h0A, 9, 0, 0);
    results();
  end
endmodule : prlct_tb_top

// ===== rtl/prlct_pkg.sv
// Purpose: Shared constants for the port rate-limit and cable-test register slice
// Assumes: 8-bit registers at fixed offsets, 100 MHz system clock
// Notes:   Rate codes, field positions and timing counts are named here; the special read view packs its fields by position
package prlct_pkg;
  // Register offsets
  localparam logic [7:0] OFS_P1_SPECIAL     = 8'h1A;
  localparam logic [7:0] OFS_P1_NOSUPPORT   = 8'h1B;
  localparam logic [7:0] OFS_P2_PRIO3_LIMIT = 8'h29;
  localparam logic [7:0] OFS_P2_SPECIAL     = 8'h2A;
  localparam logic [7:0] OFS_P2_FAULT_LO    = 8'h2B;
  localparam logic [7:0] OFS_P3_PRIO3_LIMIT = 8'h39;
  // Special control/status fields
  localparam int BIT_NEAR_SHORT  = 7;
  localparam int BIT_RESULT_HI   = 6;
  localparam int BIT_RESULT_LO   = 5;
  localparam int BIT_DIAG_EN     = 4;
  localparam int BIT_FORCE_LINK  = 3;
  localparam int BIT_REMOTE_LOOP = 1;
  localparam int BIT_FAULT_MSB   = 0;
  // Reset values
  localparam logic [7:0] RST_PRIO3_LIMIT = 8'h00;
  localparam logic [8:0] RST_FAULT       = 9'h000;
  localparam logic [1:0] RST_RESULT      = 2'h0;
  // Rate codes
  localparam logic [6:0] CODE_FULL_100  = 7'h64;
  localparam logic [6:0] CODE_MAX_100   = 7'h63;
  localparam logic [6:0] CODE_SUB_FIRST = 7'h65;
  localparam logic [6:0] CODE_SUB_LAST  = 7'h73;
  localparam logic [6:0] CODE_FULL_10   = 7'h0A;
  localparam logic [6:0] CODE_MAX_10    = 7'h09;
  localparam int KBPS_PER_MBPS = 1000;
  localparam int KBPS_SUB_STEP = 64;
  // Per-frame overhead bytes
  localparam int GAP_BYTES      = 12;
  localparam int PREAMBLE_BYTES = 8;
  // Credit tick: one microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : prlct_pkg

// ===== rtl/prlct_regs.sv
// Purpose: Priority-three rate-limit registers and PHY special control/status
// Assumes: Register port and MII-management mirror are synchronous single-cycle strobes
// Notes:   Reads answer one cycle after the strobe; the cable test runs in the PHY
`timescale 1ns/1ps
// Functional notes
// - Seven-bit rate code shapes priority-three ingress
// - Codes 1..0x63 limit 1..99 Mbit/s
// - Code 0 or 0x64 means full 100M
// - Codes 1..9 limit 1..9 Mbit/s
// - Code 0 or 0x0A means full 10M
// - Codes 0x65..0x73 give 64 kbit/s steps
// - Ports 1,2 also reachable via PHY management
// - Read-only near short flag in bit seven
// - Read-only two-bit test result, bits six-five
// - Host sets test enable; device self-clears
// - Results valid once enable reads zero
// - Remote loopback bit loops port at PHY
// - Nine-bit read-only fault count, split registers
// - Optional twelve gap bytes in accounting
// - Optional eight preamble bytes in accounting
module prlct_regs
  import prlct_pkg::*;
#(
  parameter int LEN_W = 11
)(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // Switch register port
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [7:0]       i_reg_wdata,
  output logic      [7:0]       o_reg_rdata,
  // PHY management mirror of the special register (0 = port 1, 1 = port 2)
  input  wire logic             i_miim_port,
  input  wire logic             i_miim_wr,
  input  wire logic             i_miim_rd,
  input  wire logic [7:0]       i_miim_wdata,
  output logic      [7:0]       o_miim_rdata,
  // Cable test engine in the PHYs, index 0 = port 1
  output logic      [1:0]       o_diag_start,
  input  wire logic [1:0]       i_diag_done,
  input  wire logic [1:0]       i_diag_short,
  input  wire logic [3:0]       i_diag_result,
  input  wire logic [17:0]      i_diag_count,
  output logic      [1:0]       o_remote_loopback,
  output logic      [1:0]       o_force_link,
  // Rate-limit accounting, index 0 = port 2, index 1 = port 3
  input  wire logic             i_gap_bytes_in_accounting,
  input  wire logic             i_count_preamble,
  input  wire logic [1:0]       i_link_100,
  input  wire logic [1:0]       i_frame_valid,
  input  wire logic [2*LEN_W-1:0] i_frame_len,
  output logic      [1:0]       o_priority_three_queue_allow
);
  if (LEN_W < 6)
    $error("prlct_regs: LEN_W too small");

  localparam logic [7:0] SPECIAL_OFS [2] = '{OFS_P1_SPECIAL, OFS_P2_SPECIAL};
  localparam logic [7:0] LIMIT_OFS   [2] = '{OFS_P2_PRIO3_LIMIT, OFS_P3_PRIO3_LIMIT};

  logic [7:0] priority_three_queue_limit_q [2];
  logic [1:0] diag_en_q;
  logic [1:0] near_short_q;
  logic [1:0] result_q [2];
  logic [8:0] fault_q [2];
  logic [1:0] spec_wr;
  logic [7:0] spec_wdata [2];
  logic [7:0] spec_view [2];
  logic [6:0] tick_cnt_q;
  logic       tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick for the shapers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q     <= (tick_cnt_q == 7'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 7'(TICK_CYC - 1)) ? 7'h00 : tick_cnt_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port special control/status and rate limit
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    // both access paths
    // Switch port wins when both write the same register in one cycle
    always_comb
    begin
      spec_wr[p]    = 1'b0;
      spec_wdata[p] = i_miim_wdata;
      if (i_reg_wr && i_reg_addr == SPECIAL_OFS[p])
      begin
        spec_wr[p]    = 1'b1;
        spec_wdata[p] = i_reg_wdata;
      end
      else if (i_miim_wr && i_miim_port == 1'(p))
        spec_wr[p] = 1'b1;
    end

    // start and self-clear; a new start in the done cycle wins
    always_ff @(posedge i_sys_clk)
    begin
      if (i_sys_rst)
      begin
        diag_en_q[p]    <= 1'b0;
        o_diag_start[p] <= 1'b0;
      end
      else
      begin
        o_diag_start[p] <= spec_wr[p] && spec_wdata[p][BIT_DIAG_EN]
                           && (!diag_en_q[p] || i_diag_done[p]);
        if (spec_wr[p] && spec_wdata[p][BIT_DIAG_EN])
          diag_en_q[p] <= 1'b1;
        else if (i_diag_done[p])
          diag_en_q[p] <= 1'b0;
      end
    end

    // only the test engine loads the results
    always_ff @(posedge i_sys_clk)
    begin
      if (i_sys_rst)
      begin
        near_short_q[p] <= 1'b0;
        result_q[p]     <= RST_RESULT;
        fault_q[p]      <= RST_FAULT;
      end
      else if (i_diag_done[p] && diag_en_q[p])
      begin
        near_short_q[p] <= i_diag_short[p];
        result_q[p]     <= i_diag_result[2*p +: 2];
        fault_q[p]      <= i_diag_count[9*p +: 9];
      end
    end

    always_ff @(posedge i_sys_clk)
    begin
      if (i_sys_rst)
      begin
        o_remote_loopback[p] <= 1'b0;
        o_force_link[p]      <= 1'b0;
      end
      else if (spec_wr[p])
      begin
        o_remote_loopback[p] <= spec_wdata[p][BIT_REMOTE_LOOP];
        o_force_link[p]      <= spec_wdata[p][BIT_FORCE_LINK];
      end
    end

    assign spec_view[p] = {near_short_q[p], result_q[p], diag_en_q[p], o_force_link[p],
                           1'b0, o_remote_loopback[p], fault_q[p][8]};

    // limit register, reserved bit held as written
    always_ff @(posedge i_sys_clk)
    begin
      if (i_sys_rst)
        priority_three_queue_limit_q[p] <= RST_PRIO3_LIMIT;
      else if (i_reg_wr && i_reg_addr == LIMIT_OFS[p])
        priority_three_queue_limit_q[p] <= i_reg_wdata;
    end

    prlct_shaper #(
      .LEN_W         (LEN_W)
    ) u_shaper (
      .i_sys_clk     (i_sys_clk),
      .i_sys_rst     (i_sys_rst),
      .i_tick        (tick_q),
      .i_link_100    (i_link_100[p]),
      .i_rate_code   (priority_three_queue_limit_q[p][6:0]),
      .i_count_gap   (i_gap_bytes_in_accounting),
      .i_count_pre   (i_count_preamble),
      .i_frame_valid (i_frame_valid[p]),
      .i_frame_len   (i_frame_len[LEN_W*p +: LEN_W]),
      .o_allow       (o_priority_three_queue_allow[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read paths; unmapped offsets read zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        OFS_P1_SPECIAL:  o_reg_rdata <= spec_view[0];
        OFS_P2_SPECIAL:  o_reg_rdata <= spec_view[1];
        OFS_P2_FAULT_LO: o_reg_rdata <= fault_q[1][7:0];
        OFS_P2_PRIO3_LIMIT: o_reg_rdata <= priority_three_queue_limit_q[0];
        OFS_P3_PRIO3_LIMIT: o_reg_rdata <= priority_three_queue_limit_q[1];
        default:         o_reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_miim_rdata <= 8'h00;
    else if (i_miim_rd)
      o_miim_rdata <= spec_view[i_miim_port];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_diag_start;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (spec_wr[1] && spec_wdata[1][BIT_DIAG_EN] && !diag_en_q[1])
      |=> (o_diag_start[1] && diag_en_q[1]) ##1 !o_diag_start[1];
  endproperty
  a_diag_start: assert property (p_diag_start)
    else $error("cable test start not issued");

  property p_diag_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (diag_en_q[0] && i_diag_done[0] && !spec_wr[0])
      |=> (!diag_en_q[0] && fault_q[0] == $past(i_diag_count[8:0]));
  endproperty
  a_diag_clear: assert property (p_diag_clear)
    else $error("test enable not cleared with results");

  property p_ro_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (spec_wr[1] && !i_diag_done[1]) |=> $stable(fault_q[1]) && $stable(result_q[1]);
  endproperty
  a_ro_hold: assert property (p_ro_hold)
    else $error("write altered read-only result");

  property p_limit_write;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_reg_wr && i_reg_addr == OFS_P3_PRIO3_LIMIT)
      ##1 !(i_reg_wr && i_reg_addr == OFS_P3_PRIO3_LIMIT)
      ##1 (i_reg_rd && i_reg_addr == OFS_P3_PRIO3_LIMIT && !i_reg_wr)
      |=> (o_reg_rdata == $past(i_reg_wdata, 3));
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("rate limit readback mismatch");

  property p_fault_read;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == OFS_P2_SPECIAL)
      |=> (o_reg_rdata[BIT_FAULT_MSB] == fault_q[1][8]
           || $past(i_diag_done[1]));
  endproperty
  a_fault_read: assert property (p_fault_read)
    else $error("fault count top bit misreported");

  property p_loop;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_miim_wr && !i_reg_wr && i_miim_port)
      |=> (o_remote_loopback[1] == $past(i_miim_wdata[BIT_REMOTE_LOOP]));
  endproperty
  a_loop: assert property (p_loop)
    else $error("remote loopback not taken from management write");
endmodule : prlct_regs

// ===== rtl/prlct_shaper.sv
// Purpose: Priority-three ingress shaper for one port, token bucket in millibits
// Assumes: i_tick is a one-cycle pulse every microsecond
// Notes:   Credit gains rate_kbps millibits per tick; a frame costs bytes*8000
`timescale 1ns/1ps
module prlct_shaper
  import prlct_pkg::*;
#(
  parameter int LEN_W     = 11,
  parameter int CREDIT_W  = 32,
  parameter int BURST_MB  = 24600000
)(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // Control
  input  wire logic             i_tick,
  input  wire logic             i_link_100,
  input  wire logic [6:0]       i_rate_code,
  input  wire logic             i_count_gap,
  input  wire logic             i_count_pre,
  // Frame accounting
  input  wire logic             i_frame_valid,
  input  wire logic [LEN_W-1:0] i_frame_len,
  output logic                  o_allow
);
  if (LEN_W < 6 || CREDIT_W < 26 || BURST_MB < 1)
    $error("prlct_shaper: parameters too small");

  logic              unlimited;
  logic [16:0]       rate_kbps;
  logic signed [CREDIT_W-1:0] credit_q;
  logic signed [CREDIT_W-1:0] cost;
  logic signed [CREDIT_W-1:0] next_credit;
  logic [LEN_W:0]    bytes;

  always_comb
  begin
    unlimited = 1'b0;
    rate_kbps = '0;
    if (i_link_100)
    begin
      if (i_rate_code == 7'h00 || i_rate_code == CODE_FULL_100 || i_rate_code > CODE_SUB_LAST)
        unlimited = 1'b1;
      else if (i_rate_code <= CODE_MAX_100)
        rate_kbps = 17'(i_rate_code * KBPS_PER_MBPS);
      else
        rate_kbps = 17'((i_rate_code - CODE_FULL_100) * KBPS_SUB_STEP);
    end
    else
    begin
      // Sub-megabit codes have no meaning at 10 Mbit/s and do not limit
      if (i_rate_code == 7'h00 || i_rate_code >= CODE_FULL_10)
        unlimited = 1'b1;
      else
        rate_kbps = 17'(i_rate_code * KBPS_PER_MBPS);
    end
  end

  always_comb
  begin
    bytes = {1'b0, i_frame_len};
    if (i_count_gap)
      bytes = bytes + (LEN_W+1)'(GAP_BYTES);
    if (i_count_pre)
      bytes = bytes + (LEN_W+1)'(PREAMBLE_BYTES);
    cost = CREDIT_W'(bytes) * CREDIT_W'(8 * KBPS_PER_MBPS);
  end

  always_comb
  begin
    next_credit = credit_q;
    if (i_tick)
      next_credit = next_credit + CREDIT_W'(rate_kbps);
    if (i_frame_valid)
      next_credit = next_credit - cost;
    if (next_credit > CREDIT_W'(BURST_MB))
      next_credit = CREDIT_W'(BURST_MB);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      credit_q <= '0;
    else if (unlimited)
      credit_q <= '0;
    else
      credit_q <= next_credit;
  end

  // Allow decision is registered so the top output comes from a flop
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_allow <= 1'b1;
    else
      o_allow <= unlimited || (next_credit >= 0);
  end

  property p_unlim_allows;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    unlimited |=> o_allow;
  endproperty
  a_unlim_allows: assert property (p_unlim_allows)
    else $error("unlimited code did not allow traffic");

  property p_cost_charged;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!unlimited && i_frame_valid && !i_tick && next_credit < CREDIT_W'(BURST_MB))
      |=> (credit_q == $past(credit_q) - $past(cost));
  endproperty
  a_cost_charged: assert property (p_cost_charged)
    else $error("frame cost not charged to credit");

  property p_overhead;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_count_gap && i_count_pre)
      |-> (bytes == {1'b0, i_frame_len} + (LEN_W+1)'(GAP_BYTES + PREAMBLE_BYTES));
  endproperty
  a_overhead: assert property (p_overhead)
    else $error("gap and preamble bytes not added");

  property p_sub_rate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_link_100 && i_rate_code == CODE_SUB_FIRST) |-> (rate_kbps == 17'(KBPS_SUB_STEP));
  endproperty
  a_sub_rate: assert property (p_sub_rate)
    else $error("first sub-megabit code is not 64 kbit/s");
endmodule : prlct_shaper
